//--- rtl/usb_irq_pkg.sv
// Types shared by the USB interrupt and breakpoint unit
`include "usb_irq_regs.svh"
package usb_irq_pkg;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic write;
	} reg_req_s;

	typedef struct packed {
		logic [`EVT_BITS-1:0] evt;
		logic [7:0] inBusy;
		logic [7:0] outBusy;
	} usb_evt_s;

	typedef enum logic [1:0] {BRK_IDLE, BRK_PULSE, BRK_HOLD} brk_state_e;
endpackage

//--- rtl/usb_irq_regs.svh
// Register offsets, field positions, reset values and timing counts of the USB interrupt unit
`ifndef USB_IRQ_REGS_SVH
`define USB_IRQ_REGS_SVH

// Printed offsets are not all multiples of four: they are indexes, byte address is index * 4
`define IN_EP_IRQ_IDX 16'h7fa9
`define OUT_EP_IRQ_IDX 16'h7faa
`define USB_EVT_IRQ_IDX 16'h7fab
`define IN_EP_IEN_IDX 16'h7fac
`define OUT_EP_IEN_IDX 16'h7fad
`define USB_EVT_IEN_IDX 16'h7fae
`define BRK_AV_IDX 16'h7faf
`define IRQ_VEC_IDX 16'h7fa8
`define BRK_ADDR_HI_IDX 16'h7fb2
`define BRK_ADDR_LO_IDX 16'h7fb3

// Event bit positions
`define EVT_SETUP_DATA 0
`define EVT_SOF 1
`define EVT_SETUP_TOK 2
`define EVT_SUSPEND 3
`define EVT_BUS_RESET 4
`define EVT_BULK_NAK 5
`define EVT_BITS 6

// Breakpoint control bit positions
`define BAV_AUTO_VEC 0
`define BAV_MATCH_EN 1
`define BAV_PULSE 2
`define BAV_BREAK 3

// Reset values
`define RST_BYTE 8'h00
`define RST_ADDR 16'h0000

// Break pulse: 8 cycles of the 24 MHz core clock, scaled to our clock
`define CORE_CLK_HZ 24000000
`define BRK_PULSE_CORE_CYC 8

`endif

//--- rtl/usb_irq_unit.sv
// USB interrupt request, enable, vector and address breakpoint unit
`include "usb_irq_regs.svh"

module usb_irq_unit #(
	parameter int CLK_HZ = 20000000,
	parameter int EP_COUNT = 8
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cpuRst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial engine events, one-cycle pulses and busy levels
	input wire usb_irq_pkg::usb_evt_s usbEvt,
	// Processor address bus
	input wire logic [15:0] cpuAddr,
	input wire logic cpuAddrValid,
	// Outputs to the core
	output logic usbIrqLine,
	output logic breakOutPin,
	output logic autoVectorEn,
	output logic [7:0] irqVector
);
	// Rounded up, so up to 48 MHz the pulse never gets shorter than the core clock figure
	localparam int PULSE_CYC_RAW =
		(`BRK_PULSE_CORE_CYC * (CLK_HZ / 1000) + (`CORE_CLK_HZ / 1000) - 1) / (`CORE_CLK_HZ / 1000);
	localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;

	logic [7:0] inIrq_reg;
	logic [7:0] outIrq_reg;
	logic [`EVT_BITS-1:0] evtIrq_reg;
	logic [7:0] inIen_reg;
	logic [7:0] outIen_reg;
	logic [7:0] evtIen_reg;
	logic [2:0] bavCtl_reg;
	logic breakFlag_reg;
	logic [15:0] brkAddr_reg;
	logic [7:0] inBusy_reg;
	logic [7:0] outBusy_reg;
	logic [3:0] pulseCnt_reg;
	usb_irq_pkg::brk_state_e brkState_reg;
	usb_irq_pkg::brk_state_e brkState_next;

	// Bus decode; index is byte address / 4, upper index byte fixed at 0x7f
	wire access = psel && penable;
	wire wrStb = access && pwrite;
	wire idxHit = paddr[31:16] == 16'h0001 && paddr[1:0] == 2'b00;
	wire [15:0] idx = {8'h7f, paddr[9:2]};
	wire mapIn = idxHit && idx == `IN_EP_IRQ_IDX;
	wire mapOut = idxHit && idx == `OUT_EP_IRQ_IDX;
	wire mapEvt = idxHit && idx == `USB_EVT_IRQ_IDX;
	wire mapInEn = idxHit && idx == `IN_EP_IEN_IDX;
	wire mapOutEn = idxHit && idx == `OUT_EP_IEN_IDX;
	wire mapEvtEn = idxHit && idx == `USB_EVT_IEN_IDX;
	wire mapBav = idxHit && idx == `BRK_AV_IDX;
	wire mapVec = idxHit && idx == `IRQ_VEC_IDX;
	wire mapBrkHi = idxHit && idx == `BRK_ADDR_HI_IDX;
	wire mapBrkLo = idxHit && idx == `BRK_ADDR_LO_IDX;
	wire mapAny = mapIn | mapOut | mapEvt | mapInEn | mapOutEn | mapEvtEn | mapBav | mapVec
		| mapBrkHi | mapBrkLo;
	wire [7:0] wByte = pwdata[7:0];

	// Busy falling edges; busy levels are same-clock engine logic
	wire [7:0] inFall = inBusy_reg & ~usbEvt.inBusy;
	wire [7:0] outFall = outBusy_reg & ~usbEvt.outBusy;

	// Set wins over a one-write clear; zero writes keep the bit
	wire [7:0] inClr = (wrStb && mapIn) ? wByte : 8'h00;
	wire [7:0] outClr = (wrStb && mapOut) ? wByte : 8'h00;
	wire [`EVT_BITS-1:0] evtClr = (wrStb && mapEvt) ? wByte[`EVT_BITS-1:0] : '0;
	wire [7:0] inIrq_next = (inIrq_reg & ~inClr) | inFall;
	wire [7:0] outIrq_next = (outIrq_reg & ~outClr) | outFall;
	wire [`EVT_BITS-1:0] evtIrq_next = (evtIrq_reg & ~evtClr) | usbEvt.evt;

	// Enables only gate the interrupt, requests stay stored
	wire [7:0] inPend = inIrq_reg & inIen_reg;
	wire [7:0] outPend = outIrq_reg & outIen_reg;
	wire [`EVT_BITS-1:0] evtPend = evtIrq_reg & evtIen_reg[`EVT_BITS-1:0];
	wire irqAny = |{inPend, outPend, evtPend};

	// Vector source: events first, then IN then OUT endpoints by lowest number
	logic [4:0] vecCode;
	always_comb begin
		vecCode = 5'h00;
		for (int i = EP_COUNT - 1; i >= 0; i--) begin
			if (outPend[i]) begin
				vecCode = 5'(`EVT_BITS + EP_COUNT + i);
			end
		end
		for (int i = EP_COUNT - 1; i >= 0; i--) begin
			if (inPend[i]) begin
				vecCode = 5'(`EVT_BITS + i);
			end
		end
		for (int i = `EVT_BITS - 1; i >= 0; i--) begin
			if (evtPend[i]) begin
				vecCode = 5'(i);
			end
		end
	end

	// Breakpoint match
	wire bpMatch = bavCtl_reg[`BAV_MATCH_EN] && cpuAddrValid && cpuAddr == brkAddr_reg;
	wire breakClr = wrStb && mapBav && wByte[`BAV_BREAK];
	wire pulseDone = pulseCnt_reg == 4'(PULSE_CYC - 1);

	always_comb begin
		brkState_next = brkState_reg;
		unique case (brkState_reg)
			usb_irq_pkg::BRK_IDLE: begin
				if (bpMatch) begin
					brkState_next = bavCtl_reg[`BAV_PULSE] ? usb_irq_pkg::BRK_PULSE
						: usb_irq_pkg::BRK_HOLD;
				end
			end
			usb_irq_pkg::BRK_PULSE: begin
				if (pulseDone) begin
					brkState_next = usb_irq_pkg::BRK_IDLE;
				end
			end
			usb_irq_pkg::BRK_HOLD: begin
				if (breakClr && !bpMatch) begin
					brkState_next = usb_irq_pkg::BRK_IDLE;
				end
			end
		endcase
	end
	wire breakFlag_next = brkState_next != usb_irq_pkg::BRK_IDLE;

	// Read mux
	wire [7:0] rByte =
		mapIn ? inIrq_reg :
		mapOut ? outIrq_reg :
		mapEvt ? {2'b00, evtIrq_reg} :
		mapInEn ? inIen_reg :
		mapOutEn ? outIen_reg :
		mapEvtEn ? evtIen_reg :
		mapBav ? {4'h0, breakFlag_reg, bavCtl_reg} :
		mapVec ? irqVector :
		mapBrkHi ? brkAddr_reg[15:8] :
		mapBrkLo ? brkAddr_reg[7:0] : 8'h00;

	// Event requests: power-on reset only, blind to processor reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evtIrq_reg <= '0;
		end else begin
			evtIrq_reg <= evtIrq_next;
		end
	end

	// Busy history survives processor reset, so no false fall follows it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inBusy_reg <= `RST_BYTE;
			outBusy_reg <= `RST_BYTE;
		end else begin
			inBusy_reg <= usbEvt.inBusy;
			outBusy_reg <= usbEvt.outBusy;
		end
	end

	// One request pair per endpoint
	for (genvar ep = 0; ep < 8; ep++) begin : g_ep
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				inIrq_reg[ep] <= 1'b0;
				outIrq_reg[ep] <= 1'b0;
			end else if (!cpuRst_b) begin
				inIrq_reg[ep] <= 1'b0;
				outIrq_reg[ep] <= 1'b0;
			end else begin
				inIrq_reg[ep] <= inIrq_next[ep];
				outIrq_reg[ep] <= outIrq_next[ep];
			end
		end
	end

	// Register write strobes
	wire wrInEn = wrStb && mapInEn;
	wire wrOutEn = wrStb && mapOutEn;
	wire wrEvtEn = wrStb && mapEvtEn;
	wire wrBav = wrStb && mapBav;
	wire wrBrkHi = wrStb && mapBrkHi;
	wire wrBrkLo = wrStb && mapBrkLo;

	// Processor reset is a sampled level, so it acts as a synchronous clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inIen_reg <= `RST_BYTE;
		end else if (!cpuRst_b) begin
			inIen_reg <= `RST_BYTE;
		end else if (wrInEn) begin
			inIen_reg <= wByte;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			outIen_reg <= `RST_BYTE;
		end else if (!cpuRst_b) begin
			outIen_reg <= `RST_BYTE;
		end else if (wrOutEn) begin
			outIen_reg <= wByte;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evtIen_reg <= `RST_BYTE;
		end else if (!cpuRst_b) begin
			evtIen_reg <= `RST_BYTE;
		end else if (wrEvtEn) begin
			evtIen_reg <= wByte;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bavCtl_reg <= 3'b000;
		end else if (!cpuRst_b) begin
			bavCtl_reg <= 3'b000;
		end else if (wrBav) begin
			bavCtl_reg <= wByte[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			brkAddr_reg[15:8] <= `RST_BYTE;
		end else if (!cpuRst_b) begin
			brkAddr_reg[15:8] <= `RST_BYTE;
		end else if (wrBrkHi) begin
			brkAddr_reg[15:8] <= wByte;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			brkAddr_reg[7:0] <= `RST_BYTE;
		end else if (!cpuRst_b) begin
			brkAddr_reg[7:0] <= `RST_BYTE;
		end else if (wrBrkLo) begin
			brkAddr_reg[7:0] <= wByte;
		end
	end

	// Breakpoint sequencer; pin and flag come from the same next value
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			brkState_reg <= usb_irq_pkg::BRK_IDLE;
			pulseCnt_reg <= 4'h0;
			breakFlag_reg <= 1'b0;
			breakOutPin <= 1'b0;
		end else if (!cpuRst_b) begin
			brkState_reg <= usb_irq_pkg::BRK_IDLE;
			pulseCnt_reg <= 4'h0;
			breakFlag_reg <= 1'b0;
			breakOutPin <= 1'b0;
		end else begin
			brkState_reg <= brkState_next;
			pulseCnt_reg <= (brkState_reg == usb_irq_pkg::BRK_PULSE && !pulseDone)
				? pulseCnt_reg + 4'h1 : 4'h0;
			breakFlag_reg <= breakFlag_next;
			breakOutPin <= breakFlag_next;
		end
	end

	// Interrupt outputs; the vector holds its last code once nothing is pending
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			usbIrqLine <= 1'b0;
			irqVector <= 8'h00;
			autoVectorEn <= 1'b0;
		end else if (!cpuRst_b) begin
			usbIrqLine <= 1'b0;
			irqVector <= 8'h00;
			autoVectorEn <= 1'b0;
		end else begin
			usbIrqLine <= irqAny;
			if (irqAny) begin
				irqVector <= {1'b0, vecCode, 2'b00};
			end
			autoVectorEn <= bavCtl_reg[`BAV_AUTO_VEC];
		end
	end

	// APB answers in the access cycle; unmapped reads zero and flag an error
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapAny;
			prdata <= (psel && !penable && !pwrite) ? {24'h000000, rByte} : 32'h0000_0000;
		end
	end
endmodule

//--- verif/sie_model.sv
// Serial engine and processor address bus stand-in
module sie_model (
	// Clock
	input wire logic clk,
	// Towards the unit
	output usb_irq_pkg::usb_evt_s usbEvt,
	output logic [15:0] cpuAddr,
	output logic cpuAddrValid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		usbEvt = '0;
		cpuAddr = 16'h0000;
		cpuAddrValid = 1'b0;
	end
	task automatic pulse(input int i);
		@(posedge clk);
		usbEvt.evt[i] <= 1'b1;
		@(posedge clk);
		usbEvt.evt[i] <= 1'b0;
	endtask
	task automatic busy(input logic [7:0] bi, input logic [7:0] bo);
		@(posedge clk);
		usbEvt.inBusy <= bi;
		usbEvt.outBusy <= bo;
	endtask
	// Invalid cycles show the flipped address, never a stale match
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		cpuAddr <= a;
		cpuAddrValid <= 1'b1;
		@(posedge clk);
		cpuAddr <= ~a;
		cpuAddrValid <= 1'b0;
	endtask
endmodule

//--- verif/usb_irq_unit_chk.sv
// Port assertions for the USB interrupt unit
`include "usb_irq_regs.svh"
module usb_irq_unit_chk #(
	parameter int CLK_HZ = 20000000,
	parameter int EP_COUNT = 8
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cpuRst_b,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Far side and core
	input wire usb_irq_pkg::usb_evt_s usbEvt,
	input wire logic [15:0] cpuAddr,
	input wire logic cpuAddrValid,
	input wire logic usbIrqLine,
	input wire logic breakOutPin,
	input wire logic autoVectorEn,
	input wire logic [7:0] irqVector
);
	logic wr, brkW, clrW, hit, pulseM, enM, anyEn;
	logic [15:0] bpA;
	assign wr = psel && penable && pready && pwrite;
	assign brkW = wr && paddr == {14'h0000, `BRK_AV_IDX, 2'b00};
	assign clrW = brkW && pwdata[3];
	assign hit = cpuAddrValid && enM && cpuAddr == bpA;
	// Shadow of the breakpoint setup, so causes can be checked from the ports alone
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{pulseM, enM, bpA, anyEn} <= '0;
		end else if (!cpuRst_b) begin
			{pulseM, enM, bpA} <= '0;
		end else begin
			if (brkW) {pulseM, enM} <= pwdata[2:1];
			if (wr && paddr == {14'h0000, `BRK_ADDR_HI_IDX, 2'b00}) bpA[15:8] <= pwdata[7:0];
			if (wr && paddr == {14'h0000, `BRK_ADDR_LO_IDX, 2'b00}) bpA[7:0] <= pwdata[7:0];
			if (wr && pwdata[7:0] != 8'h00 && paddr[9:2] inside {8'hac, 8'had, 8'hae}) anyEn <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || !cpuRst_b);
	AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
		else $error("no zero-wait answer");
	AST_BREAK_CAUSE: assert property ($rose(breakOutPin) |-> $past(hit))
		else $error("break without enabled match");
	AST_PULSE_LEN: assert property ($rose(breakOutPin) && $past(pulseM) |->
		breakOutPin [*7] ##1 !breakOutPin) else $error("break pulse length wrong");
	AST_LATCH_HOLD: assert property ($fell(breakOutPin) && !$past(pulseM) |-> $past(clrW))
		else $error("latched break dropped without clear");
	AST_PIN_FLAG: assert property (pready && !pwrite && paddr[9:2] == 8'haf |->
		prdata[3] == breakOutPin) else $error("break flag differs from pin");
	AST_AUTO_VEC: assert property (brkW |-> ##2 autoVectorEn == $past(pwdata[0], 2))
		else $error("auto-vector enable not taken");
	AST_VEC_FORM: assert property (irqVector[7] == 1'b0 && irqVector[1:0] == 2'b00)
		else $error("vector fixed bits wrong");
	AST_NO_EN_NO_IRQ: assert property (!anyEn |-> !usbIrqLine)
		else $error("interrupt with no enable set");
endmodule
bind usb_irq_unit usb_irq_unit_chk #(.CLK_HZ(CLK_HZ), .EP_COUNT(EP_COUNT)) usb_irq_unit_chk_i (.*);

//--- verif/usb_irq_unit_tb.sv
// Self-checking bench for the USB interrupt unit
`include "usb_irq_regs.svh"
module usb_irq_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, cpuRst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata;
	usb_irq_pkg::usb_evt_s usbEvt;
	logic [15:0] cpuAddr;
	logic cpuAddrValid, usbIrqLine, breakOutPin, autoVectorEn;
	logic [7:0] irqVector, rd;
	int errors, num_checks, cycles, n;
	localparam int PULSE_CYC = (8 * 20000000 + 23999999) / 24000000;
	usb_irq_unit usb_irq_unit_i (.*);
	sie_model sie_model_i (.*);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic results();
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [15:0] idx, input logic w, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {14'h0000, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask
	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk(rd, exp);
	endtask
	// Outputs settle within two cycles of their cause
	task automatic lvl(input int s, input logic e);
		repeat (3) @(posedge clk);
		chk({7'h00, s == 0 ? usbIrqLine : s == 1 ? breakOutPin : autoVectorEn}, {7'h00, e});
	endtask
	initial begin
		{errors, num_checks, cycles} = '0;
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		cpuRst_b = 1'b1;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rdc(`USB_EVT_IEN_IDX, 8'h00);
		rdc(`USB_EVT_IRQ_IDX, 8'h00);
		for (int i = 0; i < 6; i++) begin
			sie_model_i.pulse(i);
			rdc(`USB_EVT_IRQ_IDX, 8'h01 << i);
			wr(`USB_EVT_IRQ_IDX, 8'h00);
			rdc(`USB_EVT_IRQ_IDX, 8'h01 << i);
			wr(`USB_EVT_IRQ_IDX, 8'h01 << i);
			rdc(`USB_EVT_IRQ_IDX, 8'h00);
		end
		sie_model_i.pulse(2);
		wr(`USB_EVT_IEN_IDX, 8'h3b);
		lvl(0, 1'b0);
		wr(`USB_EVT_IEN_IDX, 8'h04);
		lvl(0, 1'b1);
		chk(irqVector, 8'h08);
		fork
			wr(`USB_EVT_IRQ_IDX, 8'h04);
			begin
				@(posedge clk);
				sie_model_i.pulse(2);
			end
		join
		rdc(`USB_EVT_IRQ_IDX, 8'h04);
		wr(`USB_EVT_IRQ_IDX, 8'h04);
		lvl(0, 1'b0);
		sie_model_i.pulse(4);
		cpuRst_b <= 1'b0;
		sie_model_i.pulse(3);
		cpuRst_b <= 1'b1;
		rdc(`USB_EVT_IRQ_IDX, 8'h18);
		rdc(`USB_EVT_IEN_IDX, 8'h00);
		sie_model_i.busy(8'hff, 8'h0f);
		sie_model_i.busy(8'h00, 8'h00);
		rdc(`IN_EP_IRQ_IDX, 8'hff);
		rdc(`OUT_EP_IRQ_IDX, 8'h0f);
		wr(`OUT_EP_IRQ_IDX, 8'h01);
		rdc(`OUT_EP_IRQ_IDX, 8'h0e);
		wr(`OUT_EP_IEN_IDX, 8'h02);
		lvl(0, 1'b1);
		wr(`OUT_EP_IRQ_IDX, 8'hfe);
		wr(`IN_EP_IRQ_IDX, 8'hff);
		lvl(0, 1'b0);
		wr(`BRK_ADDR_HI_IDX, 8'h12);
		wr(`BRK_ADDR_LO_IDX, 8'h34);
		sie_model_i.fetch(16'h1234);
		lvl(1, 1'b0);
		wr(`BRK_AV_IDX, 8'h02);
		sie_model_i.fetch(16'h1235);
		lvl(1, 1'b0);
		sie_model_i.fetch(16'h1234);
		lvl(1, 1'b1);
		rdc(`BRK_AV_IDX, 8'h0a);
		wr(`BRK_AV_IDX, 8'h0a);
		lvl(1, 1'b0);
		wr(`BRK_AV_IDX, 8'h06);
		sie_model_i.fetch(16'h1234);
		n = 0;
		repeat (20) @(posedge clk) n += breakOutPin;
		chk(n[7:0], PULSE_CYC[7:0]);
		wr(`BRK_AV_IDX, 8'h01);
		lvl(2, 1'b1);
		apb(16'h7fa0, 1'b0, 8'h00);
		chk({err, rd[6:0]}, 8'h80);
		results();
	end
endmodule
